// [design/drvdp_pkg.sv]
// Constants, register map and types of the drive diagnosis parameter bank
package drvdp_pkg;
    // Word addresses on the register port
    localparam logic [15:0] ADDR_FAULT_LATEST = 16'h0400;
    localparam logic [15:0] ADDR_FAULT_PREV1 = 16'h0401;
    localparam logic [15:0] ADDR_FAULT_PREV2 = 16'h0402;
    localparam logic [15:0] ADDR_FAULT_PREV3 = 16'h0403;
    localparam logic [15:0] ADDR_FAULT_PREV4 = 16'h0404;
    localparam logic [15:0] ADDR_JOG_COMMAND = 16'h0405;
    localparam logic [15:0] ADDR_FORCED_OUT = 16'h0406;
    localparam logic [15:0] ADDR_INPUT_STATUS = 16'h0407;
    localparam logic [15:0] ADDR_KEYPAD_INPUT = 16'h0408;
    localparam logic [15:0] ADDR_OUTPUT_STATUS = 16'h0409;
    localparam logic [15:0] ADDR_CAL_TRIGGER = 16'h040A;
    localparam logic [15:0] ADDR_TRIM_A = 16'h040B;
    localparam logic [15:0] ADDR_TRIM_B = 16'h040C;
    // Values after reset
    localparam logic [15:0] JOG_RESET = 16'h0014;
    localparam logic [15:0] TRIM_FACTORY_A = 16'h4000;
    localparam logic [15:0] TRIM_FACTORY_B = 16'h4000;
    // Field limits and command codes
    localparam logic [15:0] JOG_SPEED_MAX = 16'h0BB8;
    localparam logic [15:0] JOG_CMD_CCW = 16'h1386;
    localparam logic [15:0] JOG_CMD_CW = 16'h1387;
    localparam logic [15:0] JOG_CMD_STOP = 16'h1388;
    localparam logic [15:0] FORCE_MAX = 16'h001F;
    localparam logic [15:0] CAL_MAX = 16'h0006;
    localparam logic [15:0] ADJ_CAL_KEY = 16'h0014;
    localparam logic [15:0] ADJ_TRIM_KEY = 16'h0016;
    localparam logic [15:0] TRIM_MAX = 16'h7FFF;
    localparam int HIST_DEPTH = 5;
    localparam int IN_WIDTH = 8;
    localparam int OUT_WIDTH = 5;
    // Jog motion states, Gray along idle -> host jog -> input jog
    typedef enum logic [1:0] {
        JOG_IDLE = 2'b00,
        JOG_HOST_CCW = 2'b01,
        JOG_HOST_CW = 2'b11,
        JOG_INPUT = 2'b10
    } drvdp_jog_state_t;
endpackage

// [design/drvdp_wr_if.sv]
// Write strobe bundle from the register port to the trim words
`timescale 1ns/1ns
interface drvdp_wr_if;
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] adj_enable;
    modport src (output wr, output addr, output data, output adj_enable);
    modport dst (input wr, input addr, input data, input adj_enable);
endinterface

// [design/drvdp_trim_word.sv]
// One drift trim word, locked behind the adjustment key
`timescale 1ns/1ns
module drvdp_trim_word
    import drvdp_pkg::*;
#(
    parameter logic [15:0] ADDR = 16'h0000,
    parameter logic [15:0] FACTORY = 16'h0000
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    drvdp_wr_if.dst wr_if,
    output logic [15:0] value_o
);
    logic hit;
    assign hit = wr_if.wr && (wr_if.addr == ADDR) && (wr_if.adj_enable == ADJ_TRIM_KEY)
                 && (wr_if.data <= TRIM_MAX);

    // Only power-on reset loads factory value; parameter defaults never reach here
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            value_o <= FACTORY;
        end else if (hit) begin
            value_o <= wr_if.data;
        end
    end

    chk_trim_key_lock: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (wr_if.adj_enable != ADJ_TRIM_KEY) |=> $stable(value_o))
        else $error("trim word changed without adjustment key");
endmodule // drvdp_trim_word

// [design/drvdp_fault_hist.sv]
// Five-deep fault history shift register
`timescale 1ns/1ns
module drvdp_fault_hist
    import drvdp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic fault_valid_i,
    input wire logic [15:0] fault_code_i,
    output logic [HIST_DEPTH-1:0][15:0] hist_o
);
    // Entry 0 is the latest, the last entry the oldest
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            hist_o <= '0;
        end else if (fault_valid_i) begin
            for (int i = HIST_DEPTH - 1; i > 0; i--) begin
                hist_o[i] <= hist_o[i-1];
            end
            hist_o[0] <= fault_code_i;
        end
    end

    chk_hist_shift_order: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        fault_valid_i |=> (hist_o[0] == $past(fault_code_i)) && (hist_o[1] == $past(hist_o[0]))
                          && (hist_o[4] == $past(hist_o[3])))
        else $error("fault history did not shift correctly");
endmodule // drvdp_fault_hist

// [design/drvdp_bank.sv]
// Diagnosis parameter bank: fault history, jog, forced outputs, status, calibration, trims
`timescale 1ns/1ns
module drvdp_bank
    import drvdp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic reg_err_o,
    input wire logic param_default_i,
    input wire logic [15:0] adj_enable_i,
    input wire logic [IN_WIDTH-1:0] src_sel_i,
    input wire logic [IN_WIDTH-1:0] ext_in_i,
    input wire logic [IN_WIDTH-1:0] comm_in_i,
    input wire logic jog_forward_input_i,
    input wire logic jog_reverse_input_i,
    input wire logic [15:0] keypad_keys_i,
    input wire logic servo_on_i,
    input wire logic fault_valid_i,
    input wire logic [15:0] fault_code_i,
    input wire logic [OUT_WIDTH-1:0] out_func_i,
    output logic [OUT_WIDTH-1:0] dout_o,
    output logic jog_active_o,
    output logic jog_cw_o,
    output logic [15:0] jog_speed_o,
    output logic cal_start_o,
    output logic [2:0] cal_sel_o,
    output logic [15:0] trim_a_o,
    output logic [15:0] trim_b_o
);
    logic [HIST_DEPTH-1:0][15:0] hist;
    logic [15:0] jog_speed_reg;
    drvdp_jog_state_t jog_state_reg;
    drvdp_jog_state_t jog_state_next;
    logic [15:0] forced_reg;
    logic [15:0] cal_reg;
    logic [IN_WIDTH-1:0] input_status_reg;
    logic [OUT_WIDTH-1:0] output_status_reg;
    logic [15:0] keypad_reg;
    logic [15:0] rdata_next;
    logic addr_known;
    logic wr_ok;
    logic wr_jog;
    logic wr_force;
    logic wr_cal;
    logic force_active;
    logic [IN_WIDTH-1:0] in_routed;
    drvdp_wr_if wr_bus ();

    // Write bundle to the trim words
    assign wr_bus.wr = reg_wr_i;
    assign wr_bus.addr = reg_addr_i;
    assign wr_bus.data = reg_wdata_i;
    assign wr_bus.adj_enable = adj_enable_i;

    drvdp_fault_hist u_hist (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .fault_valid_i(fault_valid_i),
        .fault_code_i(fault_code_i),
        .hist_o(hist)
    );

    drvdp_trim_word #(.ADDR(ADDR_TRIM_A), .FACTORY(TRIM_FACTORY_A)) u_trim_a (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .wr_if(wr_bus.dst),
        .value_o(trim_a_o)
    );

    drvdp_trim_word #(.ADDR(ADDR_TRIM_B), .FACTORY(TRIM_FACTORY_B)) u_trim_b (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .wr_if(wr_bus.dst),
        .value_o(trim_b_o)
    );

    // Address decode for the whole window 0x0400..0x040C
    assign addr_known = (reg_addr_i >= ADDR_FAULT_LATEST) && (reg_addr_i <= ADDR_TRIM_B);

    // Per-register write qualification; out-of-range values are refused, not clipped
    assign wr_jog = reg_wr_i && (reg_addr_i == ADDR_JOG_COMMAND)
                    && ((reg_wdata_i <= JOG_SPEED_MAX) || (reg_wdata_i == JOG_CMD_CCW)
                    || (reg_wdata_i == JOG_CMD_CW) || (reg_wdata_i == JOG_CMD_STOP));
    assign wr_force = reg_wr_i && (reg_addr_i == ADDR_FORCED_OUT) && (reg_wdata_i <= FORCE_MAX);
    assign wr_cal = reg_wr_i && (reg_addr_i == ADDR_CAL_TRIGGER) && (adj_enable_i == ADJ_CAL_KEY)
                    && (reg_wdata_i != 16'h0000) && (reg_wdata_i <= CAL_MAX);

    // Write accepted somewhere; status and history words are read-only
    always_comb begin
        wr_ok = 1'b0;
        case (reg_addr_i)
            ADDR_JOG_COMMAND: wr_ok = wr_jog;
            ADDR_FORCED_OUT: wr_ok = wr_force;
            ADDR_CAL_TRIGGER: wr_ok = wr_cal;
            ADDR_TRIM_A,
            ADDR_TRIM_B: wr_ok = (adj_enable_i == ADJ_TRIM_KEY) && (reg_wdata_i <= TRIM_MAX);
            default: wr_ok = 1'b0;
        endcase
    end

    // Jog speed storage; a parameter reset restores the default speed
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            jog_speed_reg <= JOG_RESET;
        end else if (param_default_i) begin
            jog_speed_reg <= JOG_RESET;
        end else if (wr_jog && (reg_wdata_i <= JOG_SPEED_MAX)) begin
            jog_speed_reg <= reg_wdata_i;
        end
    end

    // Jog motion: host commands take priority over the jog inputs
    always_comb begin
        jog_state_next = jog_state_reg;
        case (jog_state_reg)
            JOG_IDLE: begin
                if (jog_forward_input_i || jog_reverse_input_i) begin
                    jog_state_next = JOG_INPUT;
                end
            end
            JOG_HOST_CCW,
            JOG_HOST_CW: jog_state_next = jog_state_reg;
            JOG_INPUT: begin
                // Input jog runs only while a jog input is held
                if (!jog_forward_input_i && !jog_reverse_input_i) begin
                    jog_state_next = JOG_IDLE;
                end
            end
            default: jog_state_next = JOG_IDLE;
        endcase
        if (wr_jog && (reg_wdata_i == JOG_CMD_CCW)) begin
            jog_state_next = JOG_HOST_CCW;
        end else if (wr_jog && (reg_wdata_i == JOG_CMD_CW)) begin
            jog_state_next = JOG_HOST_CW;
        end else if (wr_jog && (reg_wdata_i == JOG_CMD_STOP)) begin
            jog_state_next = JOG_IDLE;
        end
    end

    // Jog state register; parameter defaults also stop any motion
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            jog_state_reg <= JOG_IDLE;
        end else if (param_default_i) begin
            jog_state_reg <= JOG_IDLE;
        end else begin
            jog_state_reg <= jog_state_next;
        end
    end

    // Motion outputs from registers; forward input means clockwise
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            jog_active_o <= 1'b0;
            jog_cw_o <= 1'b0;
        end else begin
            jog_active_o <= (jog_state_next != JOG_IDLE) && !param_default_i;
            jog_cw_o <= (jog_state_next == JOG_HOST_CW)
                        || ((jog_state_next == JOG_INPUT) && jog_forward_input_i);
        end
    end

    // Speed output follows the stored word, never a command code
    assign jog_speed_o = jog_speed_reg;

    // Forced-output word: stored always, acted on only with servo off
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            forced_reg <= 16'h0000;
        end else if (param_default_i) begin
            forced_reg <= 16'h0000;
        end else if (wr_force) begin
            forced_reg <= reg_wdata_i;
        end
    end

    // Forcing while enabled could move a running machine, hence the servo gate
    assign force_active = (forced_reg != 16'h0000) && !servo_on_i;

    // Digital outputs and their status word, one register for both
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            output_status_reg <= '0;
        end else if (force_active) begin
            output_status_reg <= forced_reg[OUT_WIDTH-1:0];
        end else begin
            output_status_reg <= out_func_i;
        end
    end

    assign dout_o = output_status_reg;

    // Input routing per bit: connector when select is 0, host value when 1
    assign in_routed = (src_sel_i & comm_in_i) | (~src_sel_i & ext_in_i);

    // Input status snapshot, bit n is digital input n+1
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            input_status_reg <= '0;
        end else begin
            input_status_reg <= in_routed;
        end
    end

    // Keypad word sampled each cycle for reads
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            keypad_reg <= 16'h0000;
        end else begin
            keypad_reg <= keypad_keys_i;
        end
    end

    // Calibration trigger: holds last accepted code, start is a one-cycle pulse
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cal_reg <= 16'h0000;
            cal_start_o <= 1'b0;
            cal_sel_o <= 3'h0;
        end else begin
            cal_start_o <= wr_cal;
            if (param_default_i) begin
                cal_reg <= 16'h0000;
            end else if (wr_cal) begin
                cal_reg <= reg_wdata_i;
                cal_sel_o <= reg_wdata_i[2:0];
            end
        end
    end

    // Read multiplexer; unknown addresses read zero and flag an error
    always_comb begin
        rdata_next = 16'h0000;
        case (reg_addr_i)
            ADDR_FAULT_LATEST: rdata_next = hist[0];
            ADDR_FAULT_PREV1: rdata_next = hist[1];
            ADDR_FAULT_PREV2: rdata_next = hist[2];
            ADDR_FAULT_PREV3: rdata_next = hist[3];
            ADDR_FAULT_PREV4: rdata_next = hist[4];
            ADDR_JOG_COMMAND: rdata_next = jog_speed_reg;
            ADDR_FORCED_OUT: rdata_next = forced_reg;
            ADDR_INPUT_STATUS: rdata_next = {8'h00, input_status_reg};
            ADDR_KEYPAD_INPUT: rdata_next = keypad_reg;
            ADDR_OUTPUT_STATUS: rdata_next = {11'h000, output_status_reg};
            ADDR_CAL_TRIGGER: rdata_next = cal_reg;
            ADDR_TRIM_A: rdata_next = trim_a_o;
            ADDR_TRIM_B: rdata_next = trim_b_o;
            default: rdata_next = 16'h0000;
        endcase
    end

    // Answer one cycle after the request; a write that is refused flags error
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
        end else begin
            reg_ack_o <= reg_wr_i || reg_rd_i;
            reg_err_o <= (reg_rd_i && !addr_known) || (reg_wr_i && !wr_ok);
            if (reg_rd_i) begin
                reg_rdata_o <= addr_known ? rdata_next : 16'h0000;
            end
        end
    end

    // Checks on the behaviour above

    chk_jog_speed_only: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (wr_jog && (reg_wdata_i <= JOG_SPEED_MAX) && (jog_state_reg == JOG_IDLE)
         && !jog_forward_input_i && !jog_reverse_input_i && !param_default_i)
        |=> (jog_speed_reg == $past(reg_wdata_i)) && !jog_active_o)
        else $error("speed write started motion or was not stored");

    chk_jog_host_start: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (wr_jog && (reg_wdata_i == JOG_CMD_CW) && !param_default_i)
        |=> jog_active_o && jog_cw_o && (jog_state_reg == JOG_HOST_CW))
        else $error("clockwise jog command did not start clockwise motion");

    chk_jog_host_stop: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (wr_jog && (reg_wdata_i == JOG_CMD_STOP)) |=> !jog_active_o)
        else $error("stop command did not halt jog");

    chk_jog_input_run: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ((jog_state_reg == JOG_IDLE) && jog_forward_input_i && !reg_wr_i && !param_default_i)
        |=> jog_active_o && jog_cw_o)
        else $error("forward jog input did not start forward motion");

    chk_force_servo_gate: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        servo_on_i |=> (dout_o == $past(out_func_i)))
        else $error("outputs forced while servo enabled");

    chk_force_applies: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!servo_on_i && (forced_reg != 16'h0000)) |=> (dout_o == $past(forced_reg[4:0])))
        else $error("forced value did not reach outputs");

    chk_input_routing: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (src_sel_i == 8'hFF) |=> (input_status_reg == $past(comm_in_i)))
        else $error("host-sourced inputs not shown in status word");

    chk_cal_key_lock: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (reg_wr_i && (reg_addr_i == ADDR_CAL_TRIGGER) && (adj_enable_i != ADJ_CAL_KEY))
        |=> !cal_start_o && reg_err_o)
        else $error("calibration started without adjustment key");

    chk_read_only_hist: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (reg_wr_i && ((reg_addr_i == ADDR_INPUT_STATUS) || (reg_addr_i == ADDR_FAULT_LATEST)))
        |=> reg_ack_o && reg_err_o)
        else $error("write to read-only word was not refused");

    chk_jog_refused_keep: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (reg_wr_i && (reg_addr_i == ADDR_JOG_COMMAND) && !param_default_i
         && ((reg_wdata_i > JOG_CMD_STOP) || ((reg_wdata_i > JOG_SPEED_MAX) && (reg_wdata_i < JOG_CMD_CCW))))
        |=> (jog_speed_reg == $past(jog_speed_reg)) && reg_err_o)
        else $error("refused jog value changed the stored speed");

    chk_jog_ccw_start: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (wr_jog && (reg_wdata_i == JOG_CMD_CCW) && !param_default_i)
        |=> jog_active_o && !jog_cw_o && (jog_state_reg == JOG_HOST_CCW))
        else $error("counter-clockwise jog command did not start that motion");

    chk_jog_reverse_run: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        ((jog_state_reg == JOG_IDLE) && jog_reverse_input_i && !jog_forward_input_i && !reg_wr_i
         && !param_default_i) |=> jog_active_o && !jog_cw_o)
        else $error("reverse jog input did not start reverse motion");

    chk_force_zero_off: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (forced_reg == 16'h0000) |=> (dout_o == $past(out_func_i)))
        else $error("outputs forced although forcing is off");

    chk_cal_refused_code: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (reg_wr_i && (reg_addr_i == ADDR_CAL_TRIGGER) && ((reg_wdata_i == 16'h0000) || (reg_wdata_i > CAL_MAX)))
        |=> !cal_start_o && reg_err_o)
        else $error("reserved or unknown calibration code was accepted");

    chk_cal_start_pulse: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        wr_cal |=> cal_start_o && (cal_sel_o == $past(reg_wdata_i[2:0])))
        else $error("accepted calibration code did not start with its selection");

    chk_input_external: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (src_sel_i == 8'h00) |=> (input_status_reg == $past(ext_in_i)))
        else $error("connector inputs not shown in status word");
endmodule // drvdp_bank

// [test/drvdp_host.sv]
// Host controller model issuing single-word register reads and writes
`timescale 1ns/1ns
module drvdp_host (
    input wire logic core_clk_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [15:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] addr_o,
    output logic [15:0] wdata_o
);
    // Idle at time zero: no request, address and write data all zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 16'h0000;
        wdata_o = 16'h0000;
    end
    // One-cycle request, answer taken at the next falling edge
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] r, output logic e);
        @(negedge core_clk_i);
        wr_o = w;
        rd_o = !w;
        addr_o = a;
        wdata_o = d;
        @(negedge core_clk_i);
        r = rdata_i;
        e = ack_i ? err_i : 1'bx;
        wr_o = 1'b0;
        rd_o = 1'b0;
        // Released lines show inverted values so stale data never matches
        addr_o = ~a;
        wdata_o = ~d;
    endtask
endmodule // drvdp_host

// [test/testbench.sv]
// Self-checking bench for the diagnosis parameter bank
`timescale 1ns/1ns
module testbench;
    import drvdp_pkg::*;
    logic clk, resetn, wr, rd, ack, err, pdef, jf, jr, son, fv, ja, jcw, cs;
    logic [15:0] addr, wdata, rdata, adj, keys, fcode, jspd, tra, trb;
    logic [7:0] sel, ext, comm;
    logic [4:0] ofn, dout;
    logic [2:0] csel;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    drvdp_host host (.core_clk_i(clk), .ack_i(ack), .err_i(err), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
        .addr_o(addr), .wdata_o(wdata));
    drvdp_bank DUT (.core_clk_i(clk), .resetn_i(resetn), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err), .param_default_i(pdef),
        .adj_enable_i(adj), .src_sel_i(sel), .ext_in_i(ext), .comm_in_i(comm), .jog_forward_input_i(jf),
        .jog_reverse_input_i(jr), .keypad_keys_i(keys), .servo_on_i(son), .fault_valid_i(fv),
        .fault_code_i(fcode), .out_func_i(ofn), .dout_o(dout), .jog_active_o(ja), .jog_cw_o(jcw),
        .jog_speed_o(jspd), .cal_start_o(cs), .cal_sel_o(csel), .trim_a_o(tra), .trim_b_o(trb));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, well above the fewer than two hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize();
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Access with expected refusal flag; read data judged on reads only
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [15:0] x,
                       input logic e);
        logic [15:0] r;
        logic eo;
        host.access(w, a, d, r, eo);
        check({15'h0000, eo}, {15'h0000, e});
        if (!w)
            check(r, x);
    endtask
    task automatic wait2();
        repeat (2) @(negedge clk);
    endtask
    task automatic t_reset();
        for (int a = 16'h0400; a <= 16'h040A; a++)
            acc(1'b0, 16'(a), 16'h0000, (a == 16'h0405) ? JOG_RESET : 16'h0000, 1'b0);
        acc(1'b0, ADDR_TRIM_A, 16'h0000, TRIM_FACTORY_A, 1'b0);
        acc(1'b0, 16'h040D, 16'h0000, 16'h0000, 1'b1);
        check(jspd, JOG_RESET);
    endtask
    task automatic t_jog();
        acc(1'b1, ADDR_JOG_COMMAND, JOG_SPEED_MAX, 16'h0000, 1'b0);
        check({15'h0000, ja}, 16'h0000);
        check(jspd, JOG_SPEED_MAX);
        acc(1'b1, ADDR_JOG_COMMAND, 16'h0BB9, 16'h0000, 1'b1);
        acc(1'b1, ADDR_JOG_COMMAND, 16'h1389, 16'h0000, 1'b1);
        acc(1'b1, ADDR_JOG_COMMAND, JOG_CMD_CW, 16'h0000, 1'b0);
        check({14'h0000, ja, jcw}, 16'h0003);
        acc(1'b1, ADDR_JOG_COMMAND, JOG_CMD_CCW, 16'h0000, 1'b0);
        check({14'h0000, ja, jcw}, 16'h0002);
        acc(1'b1, ADDR_JOG_COMMAND, JOG_CMD_STOP, 16'h0000, 1'b0);
        check({15'h0000, ja}, 16'h0000);
        acc(1'b0, ADDR_JOG_COMMAND, 16'h0000, JOG_SPEED_MAX, 1'b0);
    endtask
    task automatic t_jog_in();
        jf = 1'b1;
        wait2();
        check({14'h0000, ja, jcw}, 16'h0003);
        jf = 1'b0;
        wait2();
        check({15'h0000, ja}, 16'h0000);
        jr = 1'b1;
        wait2();
        check({14'h0000, ja, jcw}, 16'h0002);
        jr = 1'b0;
        wait2();
    endtask
    task automatic t_force();
        ofn = 5'h0A;
        acc(1'b1, ADDR_FORCED_OUT, 16'h0015, 16'h0000, 1'b0);
        wait2();
        check({11'h000, dout}, 16'h0015);
        acc(1'b0, ADDR_OUTPUT_STATUS, 16'h0000, 16'h0015, 1'b0);
        acc(1'b1, ADDR_FORCED_OUT, 16'h0020, 16'h0000, 1'b1);
        son = 1'b1;
        wait2();
        check({11'h000, dout}, 16'h000A);
        son = 1'b0;
        acc(1'b1, ADDR_FORCED_OUT, 16'h0000, 16'h0000, 1'b0);
        wait2();
        check({11'h000, dout}, 16'h000A);
        acc(1'b1, ADDR_OUTPUT_STATUS, 16'h0001, 16'h0000, 1'b1);
    endtask
    task automatic t_inputs();
        sel = 8'hF0;
        ext = 8'h5A;
        comm = 8'h3C;
        keys = 16'hA5C3;
        wait2();
        acc(1'b0, ADDR_INPUT_STATUS, 16'h0000, 16'h003A, 1'b0);
        sel = 8'h0F;
        wait2();
        acc(1'b0, ADDR_INPUT_STATUS, 16'h0000, 16'h005C, 1'b0);
        sel = 8'hFF;
        wait2();
        acc(1'b0, ADDR_INPUT_STATUS, 16'h0000, 16'h003C, 1'b0);
        acc(1'b1, ADDR_INPUT_STATUS, 16'h00FF, 16'h0000, 1'b1);
        acc(1'b0, ADDR_KEYPAD_INPUT, 16'h0000, 16'hA5C3, 1'b0);
    endtask
    task automatic t_fault();
        fv = 1'b1;
        for (int i = 1; i <= 6; i++) begin
            fcode = 16'h0100 + 16'(i);
            @(negedge clk);
        end
        fv = 1'b0;
        @(negedge clk);
        for (int k = 0; k < HIST_DEPTH; k++)
            acc(1'b0, ADDR_FAULT_LATEST + 16'(k), 16'h0000, 16'h0106 - 16'(k), 1'b0);
        acc(1'b1, ADDR_FAULT_PREV4, 16'h0001, 16'h0000, 1'b1);
    endtask
    task automatic t_cal();
        son = 1'b0;
        adj = ADJ_TRIM_KEY;
        acc(1'b1, ADDR_CAL_TRIGGER, 16'h0001, 16'h0000, 1'b1);
        adj = ADJ_CAL_KEY;
        for (int c = 1; c <= 6; c++) begin
            acc(1'b1, ADDR_CAL_TRIGGER, 16'(c), 16'h0000, 1'b0);
            check({12'h000, cs, csel}, 16'h0008 + 16'(c));
        end
        acc(1'b1, ADDR_CAL_TRIGGER, 16'h0000, 16'h0000, 1'b1);
        acc(1'b1, ADDR_CAL_TRIGGER, 16'h0007, 16'h0000, 1'b1);
    endtask
    task automatic t_trim();
        acc(1'b1, ADDR_TRIM_A, 16'h1234, 16'h0000, 1'b1);
        adj = ADJ_TRIM_KEY;
        acc(1'b1, ADDR_TRIM_A, 16'h1234, 16'h0000, 1'b0);
        acc(1'b1, ADDR_TRIM_B, TRIM_MAX, 16'h0000, 1'b0);
        acc(1'b1, ADDR_TRIM_B, 16'h8000, 16'h0000, 1'b1);
        pdef = 1'b1;
        @(negedge clk);
        pdef = 1'b0;
        wait2();
        check(tra, 16'h1234);
        check(trb, TRIM_MAX);
        acc(1'b0, ADDR_TRIM_B, 16'h0000, TRIM_MAX, 1'b0);
        acc(1'b0, ADDR_JOG_COMMAND, 16'h0000, JOG_RESET, 1'b0);
    endtask
    // Main sequence, inputs changed on falling edges
    initial begin
        resetn = 1'b0;
        {pdef, jf, jr, son, fv} = 5'b00000;
        {adj, keys, fcode} = 48'h0;
        {sel, ext, comm} = 24'h0;
        ofn = 5'h00;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        t_reset();
        t_jog();
        t_jog_in();
        t_force();
        t_inputs();
        t_fault();
        t_cal();
        t_trim();
        summarize();
    end
endmodule // testbench
